/* File: src/serial_flash_bus_front_end.sv */
// serial flash bus front end: slave side of the opcode/address/data link, pause handling,
// address partitioning and hand-over of decoded commands to the system clock domain
// assumes sclk comes from the host and may stop outside frames; rst is the power-on detector;
// rdByte, the read-side load strobe and the lane outputs and enables live on sclk, everything else on clk
`timescale 1ns/10ps
`include "flash_bus_map.svh"
module serial_flash_bus_front_end
(
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      sclk,
   input  wire logic                      selectN,
   input  wire logic [3:0]                laneIn,
   output logic      [3:0]                laneOut,
   output logic      [3:0]                laneOe,
   input  wire logic                      quadEnable,
   input  wire logic                      writeBusy,
   input  wire logic [7:0]                rdByte,
   output logic                           rdLoad,
   output logic                           cmdValid,
   output flash_bus_pkg::cmdEvent_s       cmd,
   output logic                           wrValid,
   output logic      [7:0]                wrData,
   output logic                           paused,
   output logic                           selected,
   output logic                           standby,
   output logic                           writeProtect
);

   flash_bus_pkg::rise_s rise;
   flash_bus_pkg::rise_s riseFrame;
   flash_bus_pkg::rise_s riseKeep;
   flash_bus_pkg::rise_s next_rise;
   flash_bus_pkg::fall_s fall;
   flash_bus_pkg::fall_s next_fall;
   flash_bus_pkg::sys_s  sys;
   flash_bus_pkg::sys_s  next_sys;

   logic       frameOk;
   logic       qeLink;
   logic       holdLink;
   logic       frameRst;
   logic       oeClear;
   logic [3:0] oe;
   logic [3:0] next_oe;
   logic [6:0] sysSync;
   logic       armS;
   logic       selS;
   logic       pauseS;
   logic       sclkS;
   logic       wpS;
   logic       cmdTogS;
   logic       wrTogS;

   // ------------------------------------------------------------------
   // link domain (bus clock)
   // ------------------------------------------------------------------

   // quad enable is near static, but it crosses into the bus clock domain all the same
   flash_sync #(.WIDTH(1)) qeSync
   (
      .clk  (sclk),
      .rst  (rst),
      .din  (quadEnable),
      .dout (qeLink)
   );

   // pause level as seen at a bus clock edge; the pin is plain data once quad is on
   assign holdLink = !qeLink && !laneIn[3];

   // a deselect or the power-on detector restarts the frame at the opcode
   assign frameRst = rst || selectN;

   // lanes float at once on deselect, and on pause as soon as the clock is low
   assign oeClear  = frameRst || (holdLink && !sclk);

   // only a falling select after power-up arms the link; a select held low stays dead
   always_ff @(negedge selectN or posedge rst)
   begin
      if (rst)
         frameOk <= 1'b0;
      else
         frameOk <= 1'b1;
   end

   // rising edge: opcode, address, dummy and input data sampling
   always_comb
   begin
      flash_bus_pkg::cmdInfo_s info;
      logic [7:0]  op;
      logic [4:0]  bits;
      logic [23:0] din;
      info      = flash_bus_pkg::decode(8'h00);
      op        = {rise.opcode[6:0], laneIn[0]};
      bits      = 5'h01;
      din       = 24'h000000;
      next_rise = rise;
      // a paused or unarmed link lets the clock pass without effect
      if (frameOk && !holdLink)
      begin
         case (rise.phase)
            flash_bus_pkg::PH_OPCODE:
            begin
               next_rise.opcode = op;
               next_rise.cnt    = rise.cnt + 5'h01;
               if (rise.cnt == `OPCODE_LAST)
               begin
                  info           = flash_bus_pkg::decode(op);
                  next_rise.info = info;
                  next_rise.cnt  = 5'h00;
                  if (info.quad && !qeLink)
                     next_rise.phase = flash_bus_pkg::PH_IGNORE;
                  else if (info.hasAddr)
                     next_rise.phase = flash_bus_pkg::PH_ADDR;
                  else
                  begin
                     next_rise.cmdTog = !rise.cmdTog;
                     next_rise.phase  = info.dataOut ? flash_bus_pkg::PH_DOUT : flash_bus_pkg::PH_DIN;
                  end
               end
            end
            flash_bus_pkg::PH_ADDR:
            begin
               // dual and quad address phases take two or four bits a clock
               bits           = flash_bus_pkg::bitsPerClk(rise.info.addrW);
               next_rise.addr = flash_bus_pkg::shiftLanes(rise.addr, rise.info.addrW, laneIn);
               next_rise.cnt  = rise.cnt + bits;
               if (rise.cnt + bits == `ADDR_BITS)
               begin
                  next_rise.cnt    = 5'h00;
                  next_rise.cmdTog = !rise.cmdTog;
                  if (rise.info.dummy != `DUMMY_NONE)
                     next_rise.phase = flash_bus_pkg::PH_DUMMY;
                  else if (rise.info.dataOut)
                     next_rise.phase = flash_bus_pkg::PH_DOUT;
                  else
                     next_rise.phase = flash_bus_pkg::PH_DIN;
               end
            end
            flash_bus_pkg::PH_DUMMY:
            begin
               next_rise.cnt = rise.cnt + 5'h01;
               if (rise.cnt + 5'h01 == {1'b0, rise.info.dummy})
               begin
                  next_rise.cnt   = 5'h00;
                  next_rise.phase = rise.info.dataOut ? flash_bus_pkg::PH_DOUT : flash_bus_pkg::PH_DIN;
               end
            end
            flash_bus_pkg::PH_DIN:
            begin
               // quad program takes lane2 and lane3 from the protect and pause pins
               bits           = flash_bus_pkg::bitsPerClk(rise.info.dataW);
               din            = flash_bus_pkg::shiftLanes({16'h0000, rise.data}, rise.info.dataW, laneIn);
               next_rise.data = din[7:0];
               next_rise.cnt  = rise.cnt + bits;
               if (rise.cnt + bits == `BYTE_BITS)
               begin
                  next_rise.cnt    = 5'h00;
                  next_rise.wrData = din[7:0];
                  next_rise.wrTog  = !rise.wrTog;
               end
            end
            default:
            begin
               // output data and refused opcodes take no input until deselect
            end
         endcase
      end
   end

   // frame state restarts at the opcode on every deselect; only edges matter, not the idle level
   always_ff @(posedge sclk or posedge frameRst)
   begin
      if (frameRst)
         riseFrame <= '0;
      else
         riseFrame <= next_rise;
   end

   // event toggles and write data reset only with power, never with a deselect,
   // so the other domain sees each event exactly once
   always_ff @(posedge sclk or posedge rst)
   begin
      if (rst)
         riseKeep <= '0;
      else if (!selectN)
         riseKeep <= next_rise;
   end

   // one view of the link state: frame fields from one copy, toggles and write data from the other
   always_comb
   begin
      rise        = riseFrame;
      rise.wrData = riseKeep.wrData;
      rise.cmdTog = riseKeep.cmdTog;
      rise.wrTog  = riseKeep.wrTog;
   end

   // falling edge: output shifter, reloaded from rdByte at each byte boundary
   always_comb
   begin
      logic [7:0] src;
      logic [4:0] bits;
      src       = fall.shift;
      bits      = flash_bus_pkg::bitsPerClk(rise.info.dataW);
      next_fall = fall;
      next_fall.rdLoad = 1'b0;
      if (rise.phase == flash_bus_pkg::PH_DOUT && !holdLink)
      begin
         if (fall.left == 4'h0)
         begin
            src              = rdByte;
            next_fall.rdLoad = 1'b1;
         end
         case (rise.info.dataW)
            `LANE_X2: next_fall.out = {2'b00, src[7:6]};
            `LANE_X4: next_fall.out = src[7:4];
            default:  next_fall.out = {2'b00, src[7], 1'b0};
         endcase
         next_fall.shift = src << bits;
         next_fall.left  = (fall.left == 4'h0 ? 4'h8 : fall.left) - bits[3:0];
      end
   end

   always_ff @(negedge sclk or posedge frameRst)
   begin
      if (frameRst)
         fall <= '0;
      else
         fall <= next_fall;
   end

   // lane enables per width; cleared asynchronously since the clock stands still in a pause
   always_comb
   begin
      next_oe = 4'h0;
      if (rise.phase == flash_bus_pkg::PH_DOUT && !holdLink)
      begin
         case (rise.info.dataW)
            `LANE_X2: next_oe = `OE_X2;
            `LANE_X4: next_oe = `OE_X4;
            default:  next_oe = `OE_X1;
         endcase
      end
   end

   always_ff @(negedge sclk or posedge oeClear)
   begin
      if (oeClear)
         oe <= 4'h0;
      else
         oe <= next_oe;
   end

   // ------------------------------------------------------------------
   // system domain
   // ------------------------------------------------------------------

   flash_sync #(.WIDTH(7)) sysSyncInst
   (
      .clk  (clk),
      .rst  (rst),
      .din  ({frameOk, selectN, laneIn[3], sclk, laneIn[2], rise.cmdTog, rise.wrTog}),
      .dout (sysSync)
   );

   assign armS    = sysSync[6];
   assign selS    = sysSync[5];
   assign pauseS  = sysSync[4];
   assign sclkS   = sysSync[3];
   assign wpS     = sysSync[2];
   assign cmdTogS = sysSync[1];
   assign wrTogS  = sysSync[0];

   always_comb
   begin
      next_sys          = sys;
      next_sys.cmdValid = 1'b0;
      next_sys.wrValid  = 1'b0;
      next_sys.togPrev  = {cmdTogS, wrTogS};
      // opcode and address stay put for many bus clocks after the toggle, so a copy is safe
      if (cmdTogS != sys.togPrev[1])
      begin
         next_sys.cmdValid      = 1'b1;
         next_sys.cmd.opcode    = rise.opcode;
         next_sys.cmd.addr      = rise.addr;
         next_sys.cmd.sector    = rise.addr[23:`SECTOR_LSB];
         next_sys.cmd.halfBlock = rise.addr[23:`HALF_BLOCK_LSB];
         next_sys.cmd.block     = rise.addr[23:`BLOCK_LSB];
      end
      if (wrTogS != sys.togPrev[0])
      begin
         next_sys.wrValid = 1'b1;
         next_sys.wrData  = rise.wrData;
      end
      // write busy keeps the part out of standby whatever the bus does
      next_sys.selected = !selS && armS;
      next_sys.standby  = selS && !writeBusy;
      // pause is entered or left only while the clock is low; a deselect or quad enable clears it at once
      if (selS || quadEnable)
         next_sys.paused = 1'b0;
      else if (!sclkS)
         next_sys.paused = !pauseS;
      next_sys.writeProtect = !quadEnable && !wpS;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sys <= '0;
      else
         sys <= next_sys;
   end

   // every output straight from a flip-flop
   assign laneOut      = fall.out;
   assign laneOe       = oe;
   assign rdLoad       = fall.rdLoad;
   assign cmdValid     = sys.cmdValid;
   assign cmd          = sys.cmd;
   assign wrValid      = sys.wrValid;
   assign wrData       = sys.wrData;
   assign paused       = sys.paused;
   assign selected     = sys.selected;
   assign standby      = sys.standby;
   assign writeProtect = sys.writeProtect;

endmodule // serial_flash_bus_front_end

/* File: include/flash_bus_map.svh */
// constants of the serial flash bus front end: opcodes, dummy counts, address partitioning
// assumes inclusion by the package and by the front-end module, guarded against repeats
`ifndef FLASH_BUS_MAP_SVH
`define FLASH_BUS_MAP_SVH

// address space and its partitioning into sectors, half blocks and blocks; byte and opcode bit counts
`define ADDR_BITS        5'h18
`define SECTOR_LSB       12
`define HALF_BLOCK_LSB   15
`define BLOCK_LSB        16
`define BYTE_BITS        5'h08
`define OPCODE_LAST      5'h07

// lane width codes
`define LANE_X1          2'h0
`define LANE_X2          2'h1
`define LANE_X4          2'h2

// output enable masks per lane width
`define OE_X1            4'h2
`define OE_X2            4'h3
`define OE_X4            4'hf

// opcodes
`define OP_READ          8'h03
`define OP_FAST_READ     8'h0b
`define OP_DUAL_OUT      8'h3b
`define OP_DUAL_IO       8'hbb
`define OP_DUAL_ID       8'h92
`define OP_QUAD_OUT      8'h6b
`define OP_QUAD_IO       8'heb
`define OP_QUAD_WORD     8'he7
`define OP_QUAD_ID       8'h94
`define OP_QUAD_PROG     8'h32
`define OP_PAGE_PROG     8'h02
`define OP_SECTOR_ERASE  8'h20
`define OP_HALF_ERASE    8'h52
`define OP_BLOCK_ERASE   8'hd8

// dummy clocks between address and data
`define DUMMY_NONE       4'h0
`define DUMMY_FAST       4'h8
`define DUMMY_DUAL_IO    4'h4
`define DUMMY_QUAD_IO    4'h6
`define DUMMY_QUAD_WORD  4'h4

`endif

/* File: include/flash_bus_pkg.sv */
// types and decode helpers of the serial flash bus front end
// assumes flash_bus_map.svh on the include path
package flash_bus_pkg;
`include "flash_bus_map.svh"

   typedef logic [1:0] width_t;

   // transfer phases, gray coded along opcode -> address -> dummy -> output data
   typedef enum logic [2:0]
   {
      PH_OPCODE = 3'h0,
      PH_ADDR   = 3'h1,
      PH_DUMMY  = 3'h3,
      PH_DOUT   = 3'h2,
      PH_DIN    = 3'h6,
      PH_IGNORE = 3'h7
   } phase_e;

   typedef struct packed {
      logic       hasAddr;
      width_t     addrW;
      logic [3:0] dummy;
      logic       dataOut;
      width_t     dataW;
      logic       quad;
   } cmdInfo_s;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic [11:0] sector;
      logic [8:0]  halfBlock;
      logic [7:0]  block;
   } cmdEvent_s;

   // link state sampled on rising bus clock
   typedef struct packed {
      phase_e      phase;
      logic [7:0]  opcode;
      cmdInfo_s    info;
      logic [23:0] addr;
      logic [4:0]  cnt;
      logic [7:0]  data;
      logic [7:0]  wrData;
      logic        cmdTog;
      logic        wrTog;
   } rise_s;

   // link state launched on falling bus clock
   typedef struct packed {
      logic [7:0] shift;
      logic [3:0] left;
      logic [3:0] out;
      logic       rdLoad;
   } fall_s;

   // system clock side state
   typedef struct packed {
      logic [1:0] togPrev;
      logic       cmdValid;
      cmdEvent_s  cmd;
      logic       wrValid;
      logic [7:0] wrData;
      logic       paused;
      logic       selected;
      logic       standby;
      logic       writeProtect;
   } sys_s;

   function automatic cmdInfo_s decode(input logic [7:0] op);
      cmdInfo_s i;
      i = '{hasAddr: 1'b0, addrW: `LANE_X1, dummy: `DUMMY_NONE, dataOut: 1'b0, dataW: `LANE_X1, quad: 1'b0};
      case (op)
         `OP_READ:         i = '{1'b1, `LANE_X1, `DUMMY_NONE, 1'b1, `LANE_X1, 1'b0};
         `OP_FAST_READ:    i = '{1'b1, `LANE_X1, `DUMMY_FAST, 1'b1, `LANE_X1, 1'b0};
         `OP_DUAL_OUT:     i = '{1'b1, `LANE_X1, `DUMMY_FAST, 1'b1, `LANE_X2, 1'b0};
         `OP_DUAL_IO:      i = '{1'b1, `LANE_X2, `DUMMY_DUAL_IO, 1'b1, `LANE_X2, 1'b0};
         `OP_DUAL_ID:      i = '{1'b1, `LANE_X2, `DUMMY_DUAL_IO, 1'b1, `LANE_X2, 1'b0};
         `OP_QUAD_OUT:     i = '{1'b1, `LANE_X1, `DUMMY_FAST, 1'b1, `LANE_X4, 1'b1};
         `OP_QUAD_IO:      i = '{1'b1, `LANE_X4, `DUMMY_QUAD_IO, 1'b1, `LANE_X4, 1'b1};
         `OP_QUAD_WORD:    i = '{1'b1, `LANE_X4, `DUMMY_QUAD_WORD, 1'b1, `LANE_X4, 1'b1};
         `OP_QUAD_ID:      i = '{1'b1, `LANE_X4, `DUMMY_QUAD_IO, 1'b1, `LANE_X4, 1'b1};
         `OP_QUAD_PROG:    i = '{1'b1, `LANE_X1, `DUMMY_NONE, 1'b0, `LANE_X4, 1'b1};
         `OP_PAGE_PROG,
         `OP_SECTOR_ERASE,
         `OP_HALF_ERASE,
         `OP_BLOCK_ERASE:  i = '{1'b1, `LANE_X1, `DUMMY_NONE, 1'b0, `LANE_X1, 1'b0};
         default:          i = '{1'b0, `LANE_X1, `DUMMY_NONE, 1'b0, `LANE_X1, 1'b0};
      endcase
      return i;
   endfunction

   function automatic logic [4:0] bitsPerClk(input width_t w);
      case (w)
         `LANE_X2: return 5'h02;
         `LANE_X4: return 5'h04;
         default:  return 5'h01;
      endcase
   endfunction

   // shift lanes in msb first; on wider lanes the highest lane carries the highest bit
   function automatic logic [23:0] shiftLanes(input logic [23:0] v, input width_t w, input logic [3:0] l);
      case (w)
         `LANE_X2: return {v[21:0], l[1:0]};
         `LANE_X4: return {v[19:0], l[3:0]};
         default:  return {v[22:0], l[0]};
      endcase
   endfunction

endpackage

/* File: src/flash_sync.sv */
// two-flop level synchroniser, one bit per lane of the vector
// assumes asynchronous active-high reset of the receiving domain
`timescale 1ns/10ps
module flash_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } state_s;

   state_s state;
   state_s next_state;

   // first stage is read only by the second stage
   always_comb
   begin
      next_state.meta   = din;
      next_state.stable = state.meta;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state <= '0;
      else
         state <= next_state;
   end

   assign dout = state.stable;

endmodule // flash_sync

/* File: tb/flash_host_model.sv */
// host controller model: link clock, select and host side of the lanes
// assumes the bench resolves each lane; lanes 2 and 3 are pulled up
`timescale 1ns/10ps
module flash_host_model
(
   input  wire logic [3:0] laneIn,
   output logic            sclk,
   output logic            selectN,
   output logic      [3:0] hOut
);
   logic idleHi = 1'b0; // low for mode 0, high for mode 3
   // clock stands still outside frames
   initial
   begin
      sclk = 1'b0;
      selectN = 1'b0;
      hOut = 4'hc;
      // select follows the supply up, so it rises only once power-on reset is on
      #2;
      selectN = 1'b1;
   end
   // select moves only with the clock parked at idle
   task sel(input logic v);
      sclk = idleHi;
      #20;
      selectN = v;
      #20;
   endtask
   // pause only while selected, clock low
   task pin(input int i, input logic v);
      hOut[i] = v;
   endtask
   // msb first, top lane top bit; w of 0 releases lanes
   task shift(input logic [31:0] v, input int n, input int w);
      for (int i = 0; i < n; i++)
      begin
         sclk = 1'b0;
         hOut[1:0] = ~hOut[1:0]; // a released lane 0 or 1 never keeps its level
         for (int j = 0; j < w; j++)
            hOut[j] = v[32 - w + j];
         v = v << w;
         #15;
         sclk = 1'b1;
         #15;
      end
   endtask
   // sample at the rising edge what the falling edge launched
   task recv(output logic [7:0] b, input int n, input int w);
      b = 8'h00;
      for (int i = 0; i < n; i++)
      begin
         sclk = 1'b0;
         #15;
         sclk = 1'b1;
         for (int j = w - 1; j >= 0; j--)
            b = {b[6:0], laneIn[(w == 1) ? 1 : j]}; // single lane answers on lane1
         #15;
      end
   endtask
endmodule // flash_host_model

/* File: tb/serial_flash_bus_front_end_chk.sv */
// port checker of the serial flash bus front end
// assumes clk samples all pins, link pins asynchronously
`timescale 1ns/10ps
module serial_flash_bus_front_end_chk
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       sclk,
   input wire logic       selectN,
   input wire logic [3:0] laneIn,
   input wire logic [3:0] laneOut,
   input wire logic [3:0] laneOe,
   input wire logic       quadEnable,
   input wire logic       writeBusy,
   input wire logic [7:0] rdByte,
   input wire logic       rdLoad,
   input wire logic       cmdValid,
   input wire flash_bus_pkg::cmdEvent_s cmd,
   input wire logic       wrValid,
   input wire logic [7:0] wrData,
   input wire logic       paused,
   input wire logic       selected,
   input wire logic       standby,
   input wire logic       writeProtect
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // six samples cover the two-to-three cycle crossing latency
   sequence sPause; (!selectN && !laneIn[3] && !quadEnable && !sclk)[*6]; endsequence
   sequence sFree; (laneIn[3] && !sclk)[*6]; endsequence
   chk_pause_entry : assert property (sPause |-> paused)
      else $error("pause not entered");
   chk_pause_exit : assert property (sFree |-> !paused)
      else $error("pause not left");
   chk_pause_float : assert property (paused |-> laneOe == 4'h0)
      else $error("lane driven in pause");
   chk_deselect_float : assert property (selectN [*2] |-> laneOe == 4'h0)
      else $error("lane driven unselected");
   chk_quad_lanes : assert property ((!quadEnable) [*8] |-> laneOe[3:2] == 2'h0)
      else $error("quad lanes without enable");
   chk_addr_split : assert property (cmdValid |->
      {cmd.sector, cmd.halfBlock, cmd.block} == {cmd.addr[23:12], cmd.addr[23:15], cmd.addr[23:16]})
      else $error("bad address split");
   chk_standby_level : assert property ($stable({selectN, writeBusy}) [*5] |-> standby == (selectN && !writeBusy))
      else $error("bad standby");
   chk_wp_level : assert property ($stable({quadEnable, laneIn[2]}) [*6] |-> writeProtect == !(quadEnable || laneIn[2]))
      else $error("bad write protect");
endmodule // serial_flash_bus_front_end_chk
bind serial_flash_bus_front_end serial_flash_bus_front_end_chk i_chk (.*);

/* File: tb/serial_flash_bus_front_end_bench.sv */
// bench of the serial flash bus front end against a host model
// assumes the model owns the link clock, select and host lanes
`timescale 1ns/10ps
module serial_flash_bus_front_end_bench;
   logic       clk = 1'b0;
   logic       rst = 1'b0;
   logic       quadEnable = 1'b0;
   logic       writeBusy = 1'b0;
   logic [7:0] rdByte = 8'ha5;
   logic       sclk, selectN, rdLoad, cmdValid, wrValid, paused, selected, standby, writeProtect;
   logic [3:0] laneIn, laneOut, laneOe, hOut;
   logic [7:0] wrData, b;
   int         error_cnt = 0;
   int         num_checks = 0;
   int         nCmd = 0;
   int         nWr = 0;
   int         eC = 0;
   int         nLd = 0;
   flash_bus_pkg::cmdEvent_s cmd;
   serial_flash_bus_front_end i_dut
   (
      .clk(clk), .rst(rst), .sclk(sclk), .selectN(selectN),
      .laneIn(laneIn), .laneOut(laneOut), .laneOe(laneOe),
      .quadEnable(quadEnable), .writeBusy(writeBusy), .rdByte(rdByte), .rdLoad(rdLoad),
      .cmdValid(cmdValid), .cmd(cmd), .wrValid(wrValid), .wrData(wrData),
      .paused(paused), .selected(selected), .standby(standby), .writeProtect(writeProtect)
   );
   flash_host_model host
   (
      .laneIn(laneIn), .sclk(sclk), .selectN(selectN), .hOut(hOut)
   );
   // count read-side load strobes, seen one falling edge late
   always @(negedge sclk)
      nLd += (rdLoad === 1'b1);
   assign laneIn = (laneOe & laneOut) | (~laneOe & hOut); // device wins where enabled
   initial forever #4 clk = ~clk;
   // count event pulses
   always @(posedge clk)
   begin
      nCmd += (cmdValid === 1'b1);
      nWr += (wrValid === 1'b1);
   end
   task chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [63:0] ev(input logic [7:0] op, input logic [23:0] a);
      return {op, a, a[23:12], a[23:15], a[23:16]};
   endfunction
   // events cross late, so wait before counting
   task ends(input int dc, input logic [63:0] e);
      repeat (12) @(negedge clk);
      eC += dc;
      chk(nCmd, eC);
      if (dc > 0)
         chk(cmd, e);
      $display("test done at %0t", $time);
   endtask
   task t_rd(input logic [7:0] op, input int aw, input int dm, input int dw, input logic [3:0] oe);
      rdByte = op ^ 8'h5a;
      nLd = 0;
      host.sel(1'b0);
      host.shift({op, 24'h0}, 8, 1);
      host.shift({24'h5a5f3c, 8'h0}, 24 / aw, aw);
      host.shift(32'h0, dm, 0);
      host.recv(b, 8 / dw, dw);
      chk(b, rdByte);
      chk(nLd, 1);
      chk({selected, laneOe}, {1'b1, oe});
      host.sel(1'b1);
      ends(1, ev(op, 24'h5a5f3c));
   endtask
   task t_refuse;
      host.sel(1'b0);
      host.shift({8'h6b, 24'h0}, 32, 1);
      host.recv(b, 2, 4);
      chk(laneOe, 4'h0);
      host.sel(1'b1);
      ends(0, 0);
   endtask
   task t_pause;
      host.sel(1'b0);
      host.shift({8'h20, 24'habcdef}, 20, 1);
      host.sclk = 1'b0;
      host.pin(3, 1'b0);
      repeat (8) @(negedge clk);
      chk(paused, 1'b1);
      host.shift(32'hffffffff, 2, 1);
      host.sclk = 1'b0;
      host.pin(3, 1'b1);
      repeat (8) @(negedge clk);
      chk(paused, 1'b0);
      host.shift({12'hdef, 20'h0}, 12, 1);
      host.sel(1'b1);
      ends(1, ev(8'h20, 24'habcdef));
   endtask
   task t_abort(input logic q);
      host.sel(1'b0);
      host.shift({8'h02, 24'h0}, 12, 1);
      host.sclk = 1'b0;
      host.pin(3, 1'b0);
      repeat (8) @(negedge clk);
      chk(paused, !q);
      host.sel(1'b1);
      repeat (8) @(negedge clk);
      chk(paused, 1'b0);
      host.pin(3, 1'b1);
      ends(0, 0);
   endtask
   task t_status;
      @(negedge clk);
      writeBusy = 1'b1;
      host.pin(2, 1'b0);
      repeat (8) @(negedge clk);
      chk({standby, writeProtect}, {1'b0, !quadEnable});
      writeBusy = 1'b0;
      host.pin(2, 1'b1);
      repeat (8) @(negedge clk);
      chk({standby, writeProtect}, 2'h2);
      $display("test done at %0t", $time);
   endtask
   task t_prog;
      host.sel(1'b0);
      host.shift({8'h32, 24'h00f001}, 32, 1);
      host.shift({8'hc3, 24'h0}, 2, 4);
      host.sel(1'b1);
      ends(1, ev(8'h32, 24'h00f001));
      chk({nWr[7:0], wrData}, 16'h01c3);
   endtask
   // select held low through a second reset stays ignored
   task t_power;
      host.sel(1'b0);
      @(negedge clk);
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      host.shift({8'h03, 24'h0}, 32, 1);
      chk(selected, 1'b0);
      host.sel(1'b1);
      ends(0, 0);
   endtask
   task results;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // runs far short of this span
   initial
   begin
      #300000;
      error_cnt++;
      results;
   end
   initial
   begin
      // raise reset after time zero so every asynchronous reset sees an edge
      #1;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_status;
      t_rd(8'h03, 1, 0, 1, 4'h2);
      host.idleHi = 1'b1;
      t_rd(8'h0b, 1, 8, 1, 4'h2);
      host.idleHi = 1'b0;
      t_rd(8'h3b, 1, 8, 2, 4'h3);
      t_rd(8'hbb, 2, 4, 2, 4'h3);
      t_rd(8'h92, 2, 4, 2, 4'h3);
      t_refuse;
      t_pause;
      t_abort(1'b0);
      t_rd(8'h03, 1, 0, 1, 4'h2);
      @(negedge clk);
      quadEnable = 1'b1;
      t_status;
      t_abort(1'b1);
      t_rd(8'h6b, 1, 8, 4, 4'hf);
      t_rd(8'heb, 4, 6, 4, 4'hf);
      t_rd(8'he7, 4, 4, 4, 4'hf);
      t_rd(8'h94, 4, 6, 4, 4'hf);
      t_prog;
      t_power;
      results;
   end
endmodule // serial_flash_bus_front_end_bench
